//--- verilog/rug_defs.svh
// register map, field positions and reset values of the uart/global/interrupt-enable bank
`ifndef RUG_DEFS_SVH
`define RUG_DEFS_SVH

// ----------------------------------------------------------------------------
// offsets
// ----------------------------------------------------------------------------
`define RUG_OFS_UART   8'h50
`define RUG_OFS_REV    8'hB0
`define RUG_OFS_GLB    8'hB2
`define RUG_OFS_IEN    8'hB3

// ----------------------------------------------------------------------------
// reset values and implemented-bit masks
// ----------------------------------------------------------------------------
`define RUG_RST_UART   8'h02
`define RUG_RST_GLB    8'h00
`define RUG_RST_IEN    8'h00
`define RUG_MSK_UART   8'hDF
`define RUG_MSK_GLB    8'h58
`define RUG_MSK_IEN    8'hCC
`define RUG_REV_DFLT   8'h5A

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define RUG_B_LINE_SWAP    4
`define RUG_B_SRC_VALID    3
`define RUG_B_DIR_REV      2
`define RUG_B_SRC_SEL      1
`define RUG_B_SOFT_EN      0
`define RUG_B_SOFT_RST     7
`define RUG_B_PORT_DIS     6
`define RUG_B_DRIVE_TYPE   4
`define RUG_B_POLARITY     3
`define RUG_B_RISE_EN      7
`define RUG_B_FALL_EN      6
`define RUG_B_WAKE_EN      3
`define RUG_B_DISC_EN      2

`endif

//--- verilog/rug_pkg.sv
// types of the uart/global/interrupt-enable register bank
package rug_pkg;

  typedef enum logic [0:0] {
    RUG_TRIG_EDGE  = 1'b0,
    RUG_TRIG_LEVEL = 1'b1
  } rug_trig_e;

  typedef struct packed {
    logic [7:0] uart;
    logic [7:0] glb;
    logic [7:0] ien;
    logic       soft_pend;
    logic       rst_out;
    logic       disabled;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic       aux_prev;
    logic       aux_prev_ok;
    logic [3:0] pend;
    logic [7:0] rd_data;
    logic       uart_active;
    logic       to_eusb;
    logic       eusb_minus;
    logic       to_usb;
    logic       usb_minus;
    logic       irq_out;
    logic       irq_oe;
    logic       irq_asserted;
  } rug_state_s;

endpackage : rug_pkg

//--- verilog/rug_bank.sv
// uart pass-through steering, global controls and first interrupt-enable set
`timescale 1ns/1ps
`include "rug_defs.svh"

module rug_bank #(
  parameter logic [7:0] REV_CODE = `RUG_REV_DFLT, // arbitrary value
  parameter int         ADDR_W   = 8
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 reset_pin_n,
  // register port from the i2c target
  input  wire logic [ADDR_W-1:0]    reg_addr,
  input  wire logic                 reg_wr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_rd,
  output logic      [7:0]           reg_rdata,
  // pins
  input  wire logic                 uart_enable_pin,
  input  wire logic                 aux_input_pin,
  input  wire logic                 aux_in_trigger_kind,
  output logic                      interrupt_pin_out,
  output logic                      interrupt_pin_oe,
  // port link state
  input  wire logic                 port_connected,
  input  wire logic                 usb_dp_rx,
  input  wire logic                 usb_dm_rx,
  input  wire logic                 eusb_dp_rx,
  input  wire logic                 eusb_dm_rx,
  input  wire logic                 remote_wake_evt,
  input  wire logic                 disconnect_evt,
  input  wire logic [3:0]           irq_clear,
  // controls to the repeater
  output logic                      device_reset,
  output logic                      port_repeater_disabled,
  output logic                      uart_active,
  output logic                      uart_to_eusb,
  output logic                      uart_eusb_line_minus,
  output logic                      uart_to_usb,
  output logic                      uart_usb_line_minus
);
  import rug_pkg::*;

  // ----------------------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------------------
  if (ADDR_W < 8) begin : g_chk
    $error("rug_bank: ADDR_W must be at least 8");
  end

  rug_state_s st;
  rug_state_s next_st;

  // sync order: [0] uart pin, [1] aux pin, [2] reset pin, [3] connected
  // usb/eusb line inputs skip the synchronisers and are registered only once, on the way out; they are
  // asynchronous by nature and only steered, never decoded here
  wire logic uart_pin_s  = st.sync2[0];
  wire logic aux_s       = st.sync2[1];
  wire logic rst_pin_low = ~st.sync2[2];
  wire logic connected_s = st.sync2[3];

  function automatic logic [7:0] read_mux(input logic [ADDR_W-1:0] a, input rug_state_s s);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      ADDR_W'(`RUG_OFS_UART): r = s.uart & `RUG_MSK_UART;
      ADDR_W'(`RUG_OFS_REV):  r = REV_CODE;
      ADDR_W'(`RUG_OFS_GLB):  r = s.glb & `RUG_MSK_GLB;
      ADDR_W'(`RUG_OFS_IEN):  r = s.ien & `RUG_MSK_IEN;
      default:                r = 8'h00;
    endcase
    return r;
  endfunction : read_mux

  // ----------------------------------------------------------------------------
  // derived terms
  // ----------------------------------------------------------------------------
  logic sel_reg;
  logic uart_en_eff;
  logic src_usb;
  logic src_eusb;
  logic lvl_rise;
  logic lvl_fall;
  logic lvl_mode;
  logic irq_any;
  logic dev_rst;
  logic rise_ev;
  logic fall_ev;
  logic [3:0] set_ev;

  always_comb begin
    // pin is forced as source unless the select bit is declared valid
    sel_reg     = st.uart[`RUG_B_SRC_VALID] & st.uart[`RUG_B_SRC_SEL];
    uart_en_eff = sel_reg ? st.uart[`RUG_B_SOFT_EN] : uart_pin_s;
    src_usb     = st.uart[`RUG_B_DIR_REV] ? usb_dm_rx : usb_dp_rx;
    src_eusb    = st.uart[`RUG_B_DIR_REV] ? eusb_dp_rx : eusb_dm_rx;
    dev_rst     = sys_rst | rst_pin_low | st.soft_pend;
    rise_ev     = st.aux_prev_ok & aux_s & ~st.aux_prev;
    fall_ev     = st.aux_prev_ok & ~aux_s & st.aux_prev;
    lvl_mode    = (aux_in_trigger_kind == RUG_TRIG_LEVEL);
    lvl_rise    = lvl_mode & st.ien[`RUG_B_RISE_EN] & aux_s;
    lvl_fall    = lvl_mode & st.ien[`RUG_B_FALL_EN] & ~aux_s;
    set_ev[0]   = ~lvl_mode & st.ien[`RUG_B_RISE_EN] & rise_ev;
    set_ev[1]   = ~lvl_mode & st.ien[`RUG_B_FALL_EN] & fall_ev;
    set_ev[2]   = st.ien[`RUG_B_WAKE_EN] & remote_wake_evt;
    set_ev[3]   = st.ien[`RUG_B_DISC_EN] & disconnect_evt;
    irq_any     = (|st.pend) | lvl_rise | lvl_fall;
  end

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  always_comb begin
    next_st       = st;
    next_st.sync1 = {port_connected, reset_pin_n, aux_input_pin, uart_enable_pin};
    next_st.sync2 = st.sync1;
    next_st.rst_out = dev_rst;
    if (dev_rst) begin
      next_st.uart        = `RUG_RST_UART;
      next_st.glb         = `RUG_RST_GLB;
      next_st.ien         = `RUG_RST_IEN;
      next_st.soft_pend   = 1'b0;
      next_st.disabled    = 1'b0;
      next_st.aux_prev    = 1'b0;
      next_st.aux_prev_ok = 1'b0;
      next_st.pend        = 4'h0;
      next_st.rd_data     = 8'h00;
      next_st.uart_active = 1'b0;
      next_st.to_eusb     = 1'b0;
      next_st.eusb_minus  = 1'b0;
      next_st.to_usb      = 1'b0;
      next_st.usb_minus   = 1'b0;
      next_st.irq_asserted = 1'b0;
      next_st.irq_out     = 1'b1;
      next_st.irq_oe      = 1'b0;
    end else begin
      if (reg_wr) begin
        case (reg_addr)
          ADDR_W'(`RUG_OFS_UART): next_st.uart = reg_wdata & `RUG_MSK_UART;
          ADDR_W'(`RUG_OFS_GLB): begin
            next_st.glb       = reg_wdata & `RUG_MSK_GLB;
            next_st.soft_pend = reg_wdata[`RUG_B_SOFT_RST];
          end
          ADDR_W'(`RUG_OFS_IEN):  next_st.ien  = reg_wdata & `RUG_MSK_IEN;
          default: ;
        endcase
      end
      if (reg_rd) begin
        next_st.rd_data = read_mux(reg_addr, st);
      end
      // disable takes hold only once the port is idle or reports disconnect
      next_st.disabled = st.glb[`RUG_B_PORT_DIS] &
                         (st.disabled | ~connected_s | disconnect_evt);
      next_st.aux_prev    = aux_s;
      next_st.aux_prev_ok = 1'b1;
      // set wins over a clear in the same cycle
      next_st.pend = (st.pend & ~irq_clear) | set_ev;
      next_st.uart_active = uart_en_eff;
      next_st.to_eusb     = uart_en_eff & src_usb;
      next_st.eusb_minus  = st.uart[`RUG_B_DIR_REV] ^ st.uart[`RUG_B_LINE_SWAP];
      next_st.to_usb      = uart_en_eff & src_eusb;
      next_st.usb_minus   = ~(st.uart[`RUG_B_DIR_REV] ^ st.uart[`RUG_B_LINE_SWAP]);
      next_st.irq_asserted = irq_any;
      if (st.glb[`RUG_B_DRIVE_TYPE]) begin
        next_st.irq_oe  = 1'b1;
        next_st.irq_out = irq_any ^ st.glb[`RUG_B_POLARITY];
      end else begin
        next_st.irq_oe  = irq_any;
        next_st.irq_out = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  // ----------------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------------
  assign reg_rdata              = st.rd_data;
  assign interrupt_pin_out      = st.irq_out;
  assign interrupt_pin_oe       = st.irq_oe;
  assign device_reset           = st.rst_out;
  assign port_repeater_disabled = st.disabled;
  assign uart_active            = st.uart_active;
  assign uart_to_eusb           = st.to_eusb;
  assign uart_eusb_line_minus   = st.eusb_minus;
  assign uart_to_usb            = st.to_usb;
  assign uart_usb_line_minus    = st.usb_minus;

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (dev_rst);

  property p_uart_enable;
    ##1 !$past(dev_rst) |-> uart_active == $past(uart_en_eff);
  endproperty
  a_uart_enable: assert property (p_uart_enable) else $error("uart enable wrong source");

  property p_pin_forced;
    (!st.uart[`RUG_B_SRC_VALID] && !dev_rst) |-> ##1 uart_active == $past(uart_pin_s);
  endproperty
  a_pin_forced: assert property (p_pin_forced) else $error("pin source not forced");

  property p_line_pair;
    1 |-> ##1 (uart_eusb_line_minus == $past(st.uart[2] ^ st.uart[4]))
              && (uart_usb_line_minus != uart_eusb_line_minus);
  endproperty
  a_line_pair: assert property (p_line_pair) else $error("uart line pairing wrong");

  sequence s_soft_wr;
    !dev_rst && reg_wr && reg_addr == ADDR_W'(`RUG_OFS_GLB) && reg_wdata[`RUG_B_SOFT_RST];
  endsequence
  sequence s_soft_done;
    ##1 st.soft_pend ##1 (st.uart == `RUG_RST_UART && st.glb == 8'h00 && st.rst_out);
  endsequence
  // the soft reset raises dev_rst itself, so only the outside sources may cancel this
  property p_soft_reset;
    disable iff (sys_rst || rst_pin_low)
    s_soft_wr |-> s_soft_done;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset did not act");

  property p_defer_disable;
    (!st.disabled && connected_s && !disconnect_evt) |=> !st.disabled;
  endproperty
  a_defer_disable: assert property (p_defer_disable) else $error("disable not deferred");

  property p_open_drain;
    !$past(dev_rst) && !$past(st.glb[`RUG_B_DRIVE_TYPE]) |-> !interrupt_pin_out
                                        && interrupt_pin_oe == st.irq_asserted;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain misdriven");

  property p_push_pull;
    !$past(dev_rst) && $past(st.glb[`RUG_B_DRIVE_TYPE]) |-> interrupt_pin_oe
      && interrupt_pin_out == (st.irq_asserted ^ $past(st.glb[`RUG_B_POLARITY]));
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("push-pull polarity wrong");

  property p_rise_edge;
    set_ev[0] |=> st.pend[0] ##1 st.irq_asserted;
  endproperty
  a_rise_edge: assert property (p_rise_edge) else $error("rise edge not pending");

  property p_wake_gate;
    (remote_wake_evt && !st.ien[`RUG_B_WAKE_EN] && !st.pend[2]) |=> !st.pend[2];
  endproperty
  a_wake_gate: assert property (p_wake_gate) else $error("wake reported while off");

  property p_irq_idle;
    (st.pend == 4'h0 && !lvl_rise && !lvl_fall && set_ev == 4'h0) |=> !st.irq_asserted;
  endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("interrupt without cause");

  property p_reserved_zero;
    reg_rd |=> (reg_rdata & ~`RUG_MSK_IEN) == 8'h00
               || $past(reg_addr) != ADDR_W'(`RUG_OFS_IEN);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");

  // ----------------------------------------------------------------------------
  // steering, sensing, reset and register checks
  // ----------------------------------------------------------------------------
  property p_steer_fwd;
    (uart_en_eff && !st.uart[`RUG_B_DIR_REV]) |=> uart_to_eusb == $past(usb_dp_rx)
                                                 && uart_to_usb == $past(eusb_dm_rx);
  endproperty
  a_steer_fwd: assert property (p_steer_fwd) else $error("accessory direction wrong");

  property p_steer_rev;
    (uart_en_eff && st.uart[`RUG_B_DIR_REV]) |=> uart_to_eusb == $past(usb_dm_rx)
                                                && uart_to_usb == $past(eusb_dp_rx);
  endproperty
  a_steer_rev: assert property (p_steer_rev) else $error("reverse direction wrong");

  property p_steer_off;
    !uart_en_eff |=> !uart_active && !uart_to_eusb && !uart_to_usb;
  endproperty
  a_steer_off: assert property (p_steer_off) else $error("uart data while off");

  property p_reg_enable;
    (st.uart[`RUG_B_SRC_VALID] && st.uart[`RUG_B_SRC_SEL])
      |=> uart_active == $past(st.uart[`RUG_B_SOFT_EN]);
  endproperty
  a_reg_enable: assert property (p_reg_enable) else $error("register enable ignored");

  property p_level_rise;
    (aux_in_trigger_kind == RUG_TRIG_LEVEL && st.ien[`RUG_B_RISE_EN] && aux_s)
      |=> st.irq_asserted;
  endproperty
  a_level_rise: assert property (p_level_rise) else $error("high level not raised");

  property p_level_fall;
    (aux_in_trigger_kind == RUG_TRIG_LEVEL && st.ien[`RUG_B_FALL_EN] && !aux_s)
      |=> st.irq_asserted;
  endproperty
  a_level_fall: assert property (p_level_fall) else $error("low level not raised");

  property p_fall_edge;
    (aux_in_trigger_kind == RUG_TRIG_EDGE && st.ien[`RUG_B_FALL_EN] && st.aux_prev_ok
     && st.aux_prev && !aux_s) |=> st.pend[1];
  endproperty
  a_fall_edge: assert property (p_fall_edge) else $error("fall edge not pending");

  property p_edge_only;
    (aux_in_trigger_kind == RUG_TRIG_EDGE && aux_s == st.aux_prev && st.pend[1:0] == 2'b00)
      |=> st.pend[1:0] == 2'b00;
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("steady level pended");

  property p_disc_report;
    (disconnect_evt && st.ien[`RUG_B_DISC_EN]) |=> st.pend[3];
  endproperty
  a_disc_report: assert property (p_disc_report) else $error("disconnect not pending");

  property p_disc_gate;
    (disconnect_evt && !st.ien[`RUG_B_DISC_EN] && !st.pend[3]) |=> !st.pend[3];
  endproperty
  a_disc_gate: assert property (p_disc_gate) else $error("disconnect while off");

  property p_pin_reset;
    disable iff (sys_rst) rst_pin_low |=> device_reset && st.uart == `RUG_RST_UART;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("reset pin did not act");

  property p_rev_const;
    (reg_rd && reg_addr == ADDR_W'(`RUG_OFS_REV)) |=> reg_rdata == REV_CODE;
  endproperty
  a_rev_const: assert property (p_rev_const) else $error("revision code changed");

  property p_wr_mask;
    (reg_wr && reg_addr == ADDR_W'(`RUG_OFS_GLB)) |=> (st.glb & ~`RUG_MSK_GLB) == 8'h00;
  endproperty
  a_wr_mask: assert property (p_wr_mask) else $error("reserved bit stored");

endmodule : rug_bank

//--- bench/rug_host.sv
// host model driving the register port in place of the i2c target
`timescale 1ns/1ps

module rug_host (
  // clock
  input  wire logic       clk,
  // register port
  output logic [7:0]      reg_addr,
  output logic            reg_wr,
  output logic [7:0]      reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end

  // ----
  // byte access
  // ----
  // released lines show the inverse so a stale value is never mistaken as held
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr

  // data is picked up a cycle and a half after the clock edge that takes the strobe, where it stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd
endmodule : rug_host

//--- bench/test_repeater_uart_global_int_cfg.sv
// self-checking bench of the uart/global/interrupt-enable register bank
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("unexpected %s: expected %h seen %h", n, e, a); end end

module test_repeater_uart_global_int_cfg;
  localparam logic [7:0] REV = 8'hA7; // arbitrary value
  logic clk = 0, sys_rst = 1, reset_pin_n = 1, uart_enable_pin = 0;
  logic aux_input_pin = 0, aux_in_trigger_kind = 0, port_connected = 0;
  logic usb_dp_rx = 1, usb_dm_rx = 0, eusb_dp_rx = 1, eusb_dm_rx = 0;
  logic remote_wake_evt = 0, disconnect_evt = 0;
  logic [3:0] irq_clear = 4'h0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rdv;
  logic reg_wr, reg_rd, interrupt_pin_out, interrupt_pin_oe, device_reset, seen;
  logic port_repeater_disabled, uart_active, uart_to_eusb, uart_eusb_line_minus;
  logic uart_to_usb, uart_usb_line_minus;
  int mismatches = 0, num_checks = 0;

  always #10 clk = ~clk;

  rug_host host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  rug_bank #(.REV_CODE(REV)) uut (.clk(clk), .sys_rst(sys_rst),
    .reset_pin_n(reset_pin_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .uart_enable_pin(uart_enable_pin), .aux_input_pin(aux_input_pin),
    .aux_in_trigger_kind(aux_in_trigger_kind), .interrupt_pin_out(interrupt_pin_out),
    .interrupt_pin_oe(interrupt_pin_oe), .port_connected(port_connected),
    .usb_dp_rx(usb_dp_rx), .usb_dm_rx(usb_dm_rx), .eusb_dp_rx(eusb_dp_rx),
    .eusb_dm_rx(eusb_dm_rx), .remote_wake_evt(remote_wake_evt),
    .disconnect_evt(disconnect_evt), .irq_clear(irq_clear),
    .device_reset(device_reset), .port_repeater_disabled(port_repeater_disabled),
    .uart_active(uart_active), .uart_to_eusb(uart_to_eusb),
    .uart_eusb_line_minus(uart_eusb_line_minus), .uart_to_usb(uart_to_usb),
    .uart_usb_line_minus(uart_usb_line_minus));

  // ----
  // helpers
  // ----
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, rdv);
    `CHK("reg_rdata", e, rdv)
  endtask : rchk

  // a few cycles cover the pin synchronisers plus the registered outputs
  task automatic ua(input logic act, input logic te, input logic tu, input logic em);
    cyc(4);
    `CHK("uart_active", act, uart_active)
    `CHK("uart_to_eusb", te, uart_to_eusb)
    `CHK("uart_to_usb", tu, uart_to_usb)
    `CHK("eusb_minus", em, uart_eusb_line_minus)
    `CHK("usb_minus", ~em, uart_usb_line_minus)
  endtask : ua

  task automatic irq(input logic oe, input logic out);
    cyc(6);
    `CHK("irq_oe", oe, interrupt_pin_oe)
    `CHK("irq_out", out, interrupt_pin_out)
  endtask : irq

  task automatic evt(input logic w, input logic d, input logic [3:0] c);
    remote_wake_evt = w;
    disconnect_evt  = d;
    irq_clear       = c;
    cyc(1);
    {remote_wake_evt, disconnect_evt, irq_clear} = 6'h00;
  endtask : evt

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    summarize();
  end

  // ----
  // tests
  // ----
  initial begin
    cyc(5);
    sys_rst = 0;
    cyc(2);
    rchk(8'h50, 8'h02); rchk(8'hB0, REV); rchk(8'hB2, 8'h00);
    rchk(8'hB3, 8'h00); rchk(8'h51, 8'h00); irq(0, 0);
    host.wr(8'h50, 8'hFF); rchk(8'h50, 8'hDF);
    host.wr(8'hB3, 8'hFF); rchk(8'hB3, 8'hCC);
    host.wr(8'hB0, 8'h00); rchk(8'hB0, REV);
    host.wr(8'hB2, 8'h7F); rchk(8'hB2, 8'h58);
    host.wr(8'hB2, 8'h00); host.wr(8'hB3, 8'h00);
    done("registers");
    host.wr(8'h50, 8'h0B); ua(1, 1, 0, 0);
    host.wr(8'h50, 8'h1B); ua(1, 1, 0, 1);
    host.wr(8'h50, 8'h0F); ua(1, 0, 1, 1);
    host.wr(8'h50, 8'h0A); ua(0, 0, 0, 0);
    host.wr(8'h50, 8'h09); ua(0, 0, 0, 0);
    host.wr(8'h50, 8'h03); ua(0, 0, 0, 0);
    uart_enable_pin = 1; ua(1, 1, 0, 0);
    host.wr(8'h50, 8'h0A); ua(0, 0, 0, 0);
    done("uart");
    host.wr(8'hB3, 8'h08); evt(1, 0, 4'h0); irq(1, 0);
    evt(0, 0, 4'h4); irq(0, 0);
    host.wr(8'hB3, 8'h00); evt(1, 0, 4'h0); irq(0, 0);
    host.wr(8'hB2, 8'h10); irq(1, 0);
    host.wr(8'hB3, 8'h04); evt(0, 1, 4'h0); irq(1, 1);
    host.wr(8'hB2, 8'h18); irq(1, 0);
    evt(0, 0, 4'h8); irq(1, 1);
    host.wr(8'hB2, 8'h08); evt(0, 1, 4'h0); irq(1, 0);
    evt(0, 0, 4'h8); host.wr(8'hB3, 8'h00); irq(0, 0);
    done("interrupt pin");
    host.wr(8'hB3, 8'h80); aux_input_pin = 1; irq(1, 0);
    aux_input_pin = 0; irq(1, 0);
    evt(0, 0, 4'h1); irq(0, 0);
    host.wr(8'hB3, 8'h40); aux_input_pin = 1; cyc(2); aux_input_pin = 0;
    irq(1, 0);
    evt(0, 0, 4'h2); aux_in_trigger_kind = 1; irq(1, 0);
    aux_input_pin = 1; irq(0, 0);
    host.wr(8'hB3, 8'hC0); irq(1, 0);
    host.wr(8'hB3, 8'h00); aux_in_trigger_kind = 0; irq(0, 0);
    done("aux input");
    port_connected = 1; host.wr(8'hB2, 8'h40); cyc(4);
    `CHK("disabled", 1'b0, port_repeater_disabled)
    evt(0, 1, 4'h0); cyc(2);
    `CHK("disabled", 1'b1, port_repeater_disabled)
    host.wr(8'hB2, 8'h00); cyc(2);
    `CHK("disabled", 1'b0, port_repeater_disabled)
    done("disable");
    host.wr(8'h50, 8'h1F); host.wr(8'hB2, 8'h80); seen = 0;
    repeat (6) begin
      cyc(1);
      seen |= device_reset;
    end
    `CHK("device_reset", 1'b1, seen)
    rchk(8'h50, 8'h02); rchk(8'hB2, 8'h00);
    host.wr(8'h50, 8'h1F); reset_pin_n = 0; cyc(5); reset_pin_n = 1; cyc(5);
    rchk(8'h50, 8'h02);
    done("soft reset");
    summarize();
  end
endmodule : test_repeater_uart_global_int_cfg
